/* hw/edge_sense.sv */
`timescale 1ns/1ps
// Edge detector for synchronous pins, polarity chosen per bit
module edge_sense #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pins and polarity (1 = rising)
  input wire logic [WIDTH-1:0] pins,
  input wire logic [WIDTH-1:0] riseSel,
  // One-cycle pulse per detected edge
  output logic [WIDTH-1:0] edges
);

  logic [WIDTH-1:0] prev_q;

  // Previous pin sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else begin
      prev_q <= pins;
    end
  end

  // Rising when selected, else falling
  for (genvar i = 0; i < WIDTH; i++) begin : g_edge
    assign edges[i] = riseSel[i] ? (pins[i] & ~prev_q[i]) : (~pins[i] & prev_q[i]);
  end

endmodule

/* hw/multifunction_timer_control.sv */
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// R1 - With the capture interrupt enable at 1, capture events raise an interrupt in capture mode.
// R2 - With capture interrupts enabled, every selected edge on either capture pin interrupts; the code raises it in capture mode only.
// R3 - With the capture interrupt enable at 0, no capture interrupt is raised.
// R4 - Compare flag two sets on a match with value two only while value two is active.
// R5 - A hardware-set comparison flag stays 1 until software clears it.
// R6 - Control B bit 7 sets when the 8-bit real-time counter wraps FFh to 00h and stays set.
// R7 - The capture edge bit picks rising (1) or falling (0) edges for both capture pins.
// R8 - The event edge bit picks rising (1) or falling (0) edges on the event pin.
// R9 - The prescale field divides the system clock by two to the field value, 1 to 128.
// R10 - The mode field selects software timer, PWM, capture/compare or event counting.
// R11 - In capture mode an edge on capture pin two sets capture flag two until cleared.
// R12 - In capture mode an edge on capture pin two copies the counter into value two.
// R13 - A counter wrap FFFFh to 0000h sets the overflow flag and interrupts if enabled.
// R14 - Capture flag one and compare flag one set on their events and stay until cleared.
// R15 - Compare and overflow interrupt enables at 1 let matches and overflows interrupt.
module multifunction_timer_control
  import timer_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Timer pins
  input wire logic captureInputOnePin,
  input wire logic captureInputTwoPin,
  input wire logic eventClockPin,
  output logic timerOut,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrlA;
    logic [7:0] ctrlB;
    logic [15:0] count;
    logic [15:0] cmpOne;
    logic [15:0] cmpTwo;
    logic [15:0] capOne;
    logic [6:0] presDiv;
    logic [7:0] rtCount;
    logic activeTwo;
    logic pwmOut;
    logic [3:0] irqStatus;
    logic [3:0] irqMask;
    logic irq;
    logic ready;
    logic [31:0] rdata;
    logic wrPend;
    logic [7:0] wrAddr;
  } state_type;

  state_type s_q, s_d;
  logic [2:0] pinEdges;
  logic capEdgeOne, capEdgeTwo, evtEdge;
  logic addrAccept, tick, step, capMode, match1, match2, overflow, rtWrap;
  mode_type mode;

  // Prescaler mask: low field-value bits all ones gives one tick per 2^n clocks
  function automatic logic [6:0] presMask(input logic [2:0] ps);
    presMask = 7'(({7'h00, 1'b1} << ps) - 8'h01);
  endfunction

  // Register read mux
  function automatic logic [31:0] readReg(input logic [7:0] a, input state_type s);
    if (a == OFS_CTRL_A) begin
      readReg = {24'h000000, s.ctrlA};
    end else if (a == OFS_CTRL_B) begin
      readReg = {24'h000000, s.ctrlB};
    end else if (a == OFS_COUNT) begin
      readReg = {16'h0000, s.count};
    end else if (a == OFS_CMP_ONE) begin
      readReg = {16'h0000, s.cmpOne};
    end else if (a == OFS_CMP_TWO) begin
      readReg = {16'h0000, s.cmpTwo};
    end else if (a == OFS_CAP_ONE) begin
      readReg = {16'h0000, s.capOne};
    end else if (a == OFS_IRQ_STATUS) begin
      readReg = {28'h0000000, s.irqStatus};
    end else if (a == OFS_IRQ_MASK) begin
      readReg = {28'h0000000, s.irqMask};
    end else begin
      readReg = 32'h00000000;
    end
  endfunction

  // Both capture pins share one polarity bit, the event pin has its own
  edge_sense #(.WIDTH(3)) u_edges (
    .clk(clk),
    .rst(rst),
    .pins({eventClockPin, captureInputTwoPin, captureInputOnePin}),
    .riseSel({s_q.ctrlB[EVENT_EDGE_SELECT], {2{s_q.ctrlB[CAPTURE_EDGE_SELECT]}}}), // R7 R8
    .edges(pinEdges)
  );
  assign capEdgeOne = pinEdges[0];
  assign capEdgeTwo = pinEdges[1];
  assign evtEdge = pinEdges[2];

  // Next-state logic; hardware sets are applied after software clears
  always_comb begin
    s_d = s_q;
    mode = mode_type'(s_q.ctrlB[MODE_LSB +: 2]); // R10
    capMode = (mode == MODE_CAPTURE);
    addrAccept = hsel && htrans[1] && hready;
    s_d.ready = 1'b1;
    s_d.wrPend = addrAccept && hwrite;
    if (addrAccept) begin
      s_d.wrAddr = {haddr[7:2], 2'b00};
    end
    // Prescaler and step source
    s_d.presDiv = s_q.presDiv + 7'h01;
    tick = (s_q.presDiv & presMask(s_q.ctrlB[PRESCALE_LSB +: 3])) ==
           presMask(s_q.ctrlB[PRESCALE_LSB +: 3]); // R9
    step = (mode == MODE_EVENT) ? evtEdge : tick; // R8
    // Comparison against the active value; capture mode only uses value one
    match1 = step && (s_q.count == s_q.cmpOne) && (capMode || !s_q.activeTwo);
    match2 = step && (s_q.count == s_q.cmpTwo) && !capMode && s_q.activeTwo; // R4
    overflow = 1'b0;
    if (step) begin
      if (!capMode && (match1 || match2)) begin
        // Period end: restart and swap the active value
        s_d.count = COUNT_RESET; // R10
        s_d.activeTwo = !s_q.activeTwo;
        if (mode == MODE_PWM) begin
          s_d.pwmOut = !s_q.pwmOut;
        end
      end else begin
        s_d.count = s_q.count + 16'h0001;
        overflow = (s_q.count == COUNT_TOP); // R13
        if (match1) begin
          s_d.pwmOut = !s_q.pwmOut;
        end
      end
    end
    // Separate real-time byte counter
    s_d.rtCount = s_q.rtCount + 8'h01;
    rtWrap = (s_q.rtCount == RT_TOP); // R6
    // Data-phase writes
    if (s_q.wrPend) begin
      if (s_q.wrAddr == OFS_CTRL_A) begin
        // Flags clear on 0, writing 1 leaves them; enables take the value
        s_d.ctrlA = (hwdata[7:0] & ~CTRL_A_FLAG_MASK) |
                    (s_q.ctrlA & hwdata[7:0] & CTRL_A_FLAG_MASK); // R5
      end else if (s_q.wrAddr == OFS_CTRL_B) begin
        s_d.ctrlB = {s_q.ctrlB[7] & hwdata[7], hwdata[6:0]};
      end else if (s_q.wrAddr == OFS_CMP_ONE) begin
        s_d.cmpOne = hwdata[15:0];
      end else if (s_q.wrAddr == OFS_CMP_TWO) begin
        s_d.cmpTwo = hwdata[15:0];
      end else if (s_q.wrAddr == OFS_IRQ_MASK) begin
        s_d.irqMask = hwdata[3:0];
      end
    end
    // Captures; the hardware copy wins over a software write to value two
    if (capMode && capEdgeOne) begin
      s_d.capOne = s_q.count;
      s_d.ctrlA[CAPTURE_FLAG_ONE] = 1'b1; // R14
    end
    if (capMode && capEdgeTwo) begin
      s_d.cmpTwo = s_q.count; // R12
      s_d.ctrlA[CAPTURE_FLAG_TWO] = 1'b1; // R11
    end
    if (match1) begin
      s_d.ctrlA[COMPARE_FLAG_ONE] = 1'b1; // R14
    end
    if (match2) begin
      s_d.ctrlA[COMPARE_FLAG_TWO] = 1'b1; // R4
    end
    if (overflow) begin
      s_d.ctrlA[OVERFLOW_FLAG] = 1'b1; // R13
    end
    if (rtWrap) begin
      s_d.ctrlB[RT_COUNTER_WRAP_FLAG] = 1'b1; // R6
    end
    // Read data is sampled in the address phase, stands in the data phase
    if (addrAccept && !hwrite) begin
      s_d.rdata = readReg({haddr[7:2], 2'b00}, s_q);
      if ({haddr[7:2], 2'b00} == OFS_IRQ_STATUS) begin
        s_d.irqStatus = 4'h0;
      end
    end
    // Sticky interrupt causes, gated by their enables except the real-time wrap, which has none; set beats read-clear
    if (capMode && (capEdgeOne || capEdgeTwo) && s_q.ctrlA[CAPTURE_IRQ_ENABLE]) begin
      s_d.irqStatus[IRQ_CAPTURE] = 1'b1; // R1 R2 R3
    end
    if ((match1 || match2) && s_q.ctrlA[COMPARE_IRQ_ENABLE]) begin
      s_d.irqStatus[IRQ_COMPARE] = 1'b1; // R15
    end
    if (overflow && s_q.ctrlA[OVERFLOW_IRQ_ENABLE]) begin
      s_d.irqStatus[IRQ_OVERFLOW] = 1'b1; // R13
    end
    if (rtWrap) begin
      s_d.irqStatus[IRQ_RT_WRAP] = 1'b1;
    end
    s_d.irq = |(s_d.irqStatus & s_d.irqMask);
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '{ctrlA: CTRL_A_RESET, ctrlB: CTRL_B_RESET, count: COUNT_RESET,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.ready;
  assign hrdata = s_q.rdata;
  assign hresp = 1'b0;
  assign timerOut = s_q.pwmOut;
  assign irq = s_q.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cap_two_flag;
    capMode && capEdgeTwo |=> s_q.ctrlA[CAPTURE_FLAG_TWO];
  endproperty
  a_cap_two_flag: assert property (p_cap_two_flag) else $error("capture flag two not set"); // R11

  property p_cap_two_copy;
    capMode && capEdgeTwo |=> s_q.cmpTwo == $past(s_q.count);
  endproperty
  a_cap_two_copy: assert property (p_cap_two_copy) else $error("value two not captured"); // R12

  property p_rising_edge;
    s_q.ctrlB[CAPTURE_EDGE_SELECT] && capMode && $rose(captureInputOnePin) |->
      ##1 s_q.ctrlA[CAPTURE_FLAG_ONE];
  endproperty
  a_rising_edge: assert property (p_rising_edge) else $error("rising capture missed"); // R7

  property p_flag_hold;
    s_q.ctrlA[COMPARE_FLAG_ONE] && !(s_q.wrPend && s_q.wrAddr == OFS_CTRL_A) |=>
      s_q.ctrlA[COMPARE_FLAG_ONE];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("compare flag one lost"); // R5

  property p_rt_wrap;
    s_q.rtCount == RT_TOP |=> s_q.ctrlB[RT_COUNTER_WRAP_FLAG] && s_q.rtCount == 8'h00;
  endproperty
  a_rt_wrap: assert property (p_rt_wrap) else $error("real-time wrap flag not set"); // R6

  property p_count_hold;
    mode != MODE_EVENT && !tick |=> $stable(s_q.count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without tick"); // R9

  property p_overflow;
    capMode && step && s_q.count == COUNT_TOP |=>
      s_q.count == COUNT_RESET && s_q.ctrlA[OVERFLOW_FLAG];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // R13

  property p_cap_irq_gate;
    $rose(s_q.irqStatus[IRQ_CAPTURE]) |-> $past(s_q.ctrlA[CAPTURE_IRQ_ENABLE]);
  endproperty
  a_cap_irq_gate: assert property (p_cap_irq_gate) else $error("capture irq while off"); // R3

  property p_cap_irq;
    capMode && capEdgeOne && s_q.ctrlA[CAPTURE_IRQ_ENABLE] |=> s_q.irqStatus[IRQ_CAPTURE];
  endproperty
  a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing"); // R1

  property p_match_two;
    match2 |=> s_q.ctrlA[COMPARE_FLAG_TWO] && s_q.count == COUNT_RESET && !s_q.activeTwo;
  endproperty
  a_match_two: assert property (p_match_two) else $error("match two not handled"); // R4

  c_pwm_toggle: cover property (mode == MODE_PWM && match1 ##1 $changed(timerOut));
  c_capture: cover property (capMode && capEdgeTwo ##[1:20] irq);
  c_overflow: cover property (overflow);

endmodule

/* hw/timer_ctrl_pkg.sv */
package timer_ctrl_pkg;

  // Byte addresses of the register words
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_ONE = 8'h0c;
  localparam logic [7:0] OFS_CMP_TWO = 8'h10;
  localparam logic [7:0] OFS_CAP_ONE = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  // Field positions in timer_irq_control_flags
  localparam int CAPTURE_FLAG_TWO = 7;
  localparam int CAPTURE_FLAG_ONE = 6;
  localparam int CAPTURE_IRQ_ENABLE = 5;
  localparam int COMPARE_FLAG_TWO = 4;
  localparam int COMPARE_FLAG_ONE = 3;
  localparam int COMPARE_IRQ_ENABLE = 2;
  localparam int OVERFLOW_FLAG = 1;
  localparam int OVERFLOW_IRQ_ENABLE = 0;
  // Flags that software clears by writing 0
  localparam logic [7:0] CTRL_A_FLAG_MASK = 8'hda;

  // Field positions in timer_mode_prescale_config
  localparam int RT_COUNTER_WRAP_FLAG = 7;
  localparam int CAPTURE_EDGE_SELECT = 6;
  localparam int EVENT_EDGE_SELECT = 5;
  localparam int PRESCALE_LSB = 2;
  localparam int MODE_LSB = 0;

  // Bits of the interrupt status and mask words
  localparam int IRQ_CAPTURE = 0;
  localparam int IRQ_COMPARE = 1;
  localparam int IRQ_OVERFLOW = 2;
  localparam int IRQ_RT_WRAP = 3;

  // Values after reset, and the top values of both counters
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  localparam logic [7:0] CTRL_B_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [7:0] RT_TOP = 8'hff;

  typedef enum logic [1:0] {
    MODE_SOFTWARE = 2'h0,
    MODE_PWM = 2'h1,
    MODE_CAPTURE = 2'h2,
    MODE_EVENT = 2'h3
  } mode_type;

endpackage

/* sim/pin_source.sv */
`timescale 1ns/1ps
// Outside source for the capture and event pins
module pin_source (
  // Clock
  input wire logic clk,
  // Pins toward the timer
  output logic capOne,
  output logic capTwo,
  output logic evt
);
  // Pins idle low
  initial begin
    capOne = 1'b0;
    capTwo = 1'b0;
    evt = 1'b0;
  end
  // Moves one pin after an edge, held two cycles so each level is sampled
  task automatic drive(input int pin, input logic lvl);
    @(posedge clk);
    case (pin)
      0: capOne <= lvl;
      1: capTwo <= lvl;
      default: evt <= lvl;
    endcase
    repeat (2) @(posedge clk);
  endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, (g), (e)); end end
module tb;
  import timer_ctrl_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hresp, timerOut, irq, capOne, capTwo, evt;
  logic [31:0] haddr, hwdata, hrdata, r, c0, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count, checks, cyc, aCyc, t0, n;
  // Clock and time-zero inputs
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
  end
  always #2 clk = ~clk;
  multifunction_timer_control DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .captureInputOnePin(capOne),
    .captureInputTwoPin(capTwo), .eventClockPin(evt), .timerOut(timerOut), .irq(irq));
  pin_source pins (.clk(clk), .capOne(capOne), .capTwo(capTwo), .evt(evt));
  task end_of_test;
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Cycle count; the ceiling cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      bad_count++;
      end_of_test();
    end
  end
  // One single transfer; address held until hready, then data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    aCyc = cyc;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // Counts output changes over 200 cycles
  task automatic toggles();
    logic p;
    n = 0;
    p = timerOut;
    repeat (200) begin
      @(posedge clk);
      if (timerOut !== p) n++;
      p = timerOut;
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    xfer(0, OFS_CTRL_B, 0); `CHK(r, 32'h0)
    `CHK(hresp, 1'b0)
    xfer(0, 8'h20, 0); `CHK(r, 32'h0)
    xfer(0, OFS_IRQ_MASK, 0); `CHK(r, 32'h0)
    xfer(1, OFS_CMP_ONE, 32'hffff);
    // Event counting on either edge; three pulses each
    for (int s = 0; s < 2; s++) begin
      xfer(1, OFS_CTRL_B, 32'h03 | (s << 5));
      xfer(0, OFS_COUNT, 0);
      c0 = r;
      repeat (3) begin
        pins.drive(2, 1'b1);
        pins.drive(2, 1'b0);
      end
      xfer(0, OFS_COUNT, 0); `CHK(r - c0, 32'h3)
    end
    // Free run: four ticks in four prescaled periods
    for (int ps = 0; ps < 8; ps++) begin
      xfer(1, OFS_CTRL_B, 32'h02 | (ps << 2));
      xfer(0, OFS_COUNT, 0);
      c0 = r;
      t0 = aCyc;
      while (cyc != t0 + (4 << ps) - 2) @(posedge clk);
      xfer(0, OFS_COUNT, 0); `CHK(r - c0, 32'h4)
    end
    // Rising capture on pin two with interrupt
    xfer(1, OFS_IRQ_MASK, 32'h1);
    xfer(1, OFS_CTRL_B, 32'h42);
    xfer(1, OFS_CTRL_A, 32'h20);
    xfer(0, OFS_COUNT, 0);
    c0 = r;
    pins.drive(1, 1'b1);
    xfer(0, OFS_COUNT, 0);
    q = r;
    xfer(0, OFS_CMP_TWO, 0); `CHK(r > c0 && r < q, 1'b1)
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'ha0)
    `CHK(irq, 1'b1)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h1)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h0)
    `CHK(irq, 1'b0)
    // Rising select on pin one: the rise captures three clocks after the count read
    xfer(0, OFS_COUNT, 0);
    c0 = r;
    pins.drive(0, 1'b1);
    pins.drive(0, 1'b0);
    xfer(0, OFS_CAP_ONE, 0); `CHK(r - c0, 32'h3)
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'he0)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h1)
    // Writing 0 to flag one clears it, the rest keep their value
    xfer(1, OFS_CTRL_A, 32'ha0);
    // Falling select: a rising edge on pin one is ignored
    xfer(1, OFS_CTRL_B, 32'h02);
    pins.drive(0, 1'b1);
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'ha0)
    xfer(1, OFS_CTRL_A, 32'h00);
    pins.drive(0, 1'b0);
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'h40)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h0)
    `CHK(irq, 1'b0)
    // Overflow in free run; bounded by the cycle ceiling
    xfer(1, OFS_IRQ_MASK, 32'h4);
    xfer(1, OFS_CMP_ONE, 32'h40);
    xfer(1, OFS_CMP_TWO, 32'h40);
    xfer(1, OFS_CTRL_A, 32'h01);
    xfer(0, OFS_IRQ_STATUS, 0);
    while (irq !== 1'b1) @(posedge clk);
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h4)
    xfer(0, OFS_CTRL_A, 0); `CHK(r & 32'h2, 32'h2)
    // Counter is small here, so both values match in software mode
    xfer(1, OFS_CTRL_B, 32'h00);
    xfer(1, OFS_CTRL_A, 32'h04);
    toggles(); `CHK(n, 0)
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'h1c)
    xfer(0, OFS_CTRL_A, 0); `CHK(r, 32'h1c)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h7, 32'h2)
    xfer(1, OFS_CTRL_B, 32'h01);
    toggles(); `CHK(n > 0, 1'b1)
    // Byte counter wraps every 256 clocks; wait past one full turn
    repeat (60) @(posedge clk);
    xfer(0, OFS_CTRL_B, 0); `CHK(r, 32'h81)
    xfer(0, OFS_IRQ_STATUS, 0); `CHK(r & 32'h8, 32'h8)
    end_of_test();
  end
endmodule
